// file: hdl/afps_pin_select.sv
`timescale 1ns/1ps
// Overview of operation
// RULE_01: mode bit clear is port, set is alternate
// RULE_02: port0_bit2 picks nmi or address_bit21
// RULE_03: port0_bit3 decodes irq0, trigger, usb clock, second
// RULE_04: port0_bit4 decodes irq1, rtc divided, rtc clock
// RULE_05: port0_bit5 irq2; debug select forces debug reset
// RULE_06: port0_bit6 is irq3 only
// RULE_07: dac pins need direction bit set
// RULE_08: mixed dac/io use needs steady io
// RULE_09: port3_bit0 picks uart0 tx or csi4 out
// RULE_10: port3_bit1 feeds uart0 rx+irq7 or csi4 in
// RULE_11: uart0 rx use disables irq7 edges
// RULE_12: irq7 use disables uart0 reception
// RULE_13: port3_bit2 baud, csi4 clock, timer p; code decodes only baud and csi4 clock (codes 00, 01)
// RULE_14: port3_bit6/7 are uart3 tx/rx
// RULE_15: port3_bit8 uart2 tx or i2c0 data
// RULE_16: port3_bit9 uart2 rx or i2c0 clock
// RULE_17: port4_bit0 csi0 in or i2c1 data
// RULE_18: port4_bit1 csi0 out or i2c1 clock
// RULE_19: port4_bit2 csi0 clock, keyret mask cleared
// RULE_20: port5_bit0 timer q in/key, out, pulse
// RULE_21: timer q capture needs edge cfg cleared
// RULE_22: unassigned codes connect nothing
`include "afps_defs.svh"
module afps_pin_select import afps_pkg::*; #(
  parameter int NPINS = `AFPS_NPINS
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [NPINS-1:0] pin_mode_ctl,
  input wire logic [NPINS-1:0] func_select_ctl,
  input wire logic [NPINS-1:0] func_extension_ctl,
  input wire logic [NPINS-1:0] port_output_type,
  input wire logic debug_mode_sel,
  input wire logic keyret_mask0,
  output logic [NPINS-1:0] pin_is_port,
  output logic [NPINS-1:0] sel_a,
  output logic [NPINS-1:0] sel_b,
  output logic [NPINS-1:0] sel_c,
  output logic [NPINS-1:0] sel_d,
  output logic debug_reset_sel,
  output logic uart_use_ok
);
  afps_route_t route [NPINS];

  // which {ext,func} codes each pin accepts; uses only a when no func bit
  function automatic afps_route_t decode(input logic mc, input logic [1:0] code, input logic [3:0] legal);
    afps_route_t r;
    r = AFPS_NONE;
    if (!mc) begin
      r = AFPS_PORT; // RULE_01
    end else if (legal[code]) begin
      case (code)
        `AFPS_SEL00: r = AFPS_ALT_A;
        `AFPS_SEL01: r = AFPS_ALT_B;
        `AFPS_SEL10: r = AFPS_ALT_C;
        `AFPS_SEL11: r = AFPS_ALT_D;
        default: r = AFPS_NONE; // RULE_22
      endcase
    end
    return r;
  endfunction

  // legal code masks per pin; pins lacking extension force ext to 0
  function automatic logic [3:0] legal_of(input int i);
    logic [3:0] m;
    m = `AFPS_LEGAL_NONE;
    case (i)
      `AFPS_P02, `AFPS_P30, `AFPS_P31, `AFPS_P38, `AFPS_P39, `AFPS_P40, `AFPS_P41: m = `AFPS_LEGAL_FN; // RULE_02 RULE_09
      `AFPS_P03: m = `AFPS_LEGAL_ALL; // RULE_03
      `AFPS_P04: m = `AFPS_LEGAL_P04; // RULE_04
      `AFPS_P32: m = `AFPS_LEGAL_FN; // RULE_13
      `AFPS_P50: m = `AFPS_LEGAL_P50; // RULE_20
      default: m = `AFPS_LEGAL_A; // RULE_06 RULE_14
    endcase
    return m;
  endfunction

  function automatic logic has_ext(input int i);
    return (i == `AFPS_P03) || (i == `AFPS_P04) || (i == `AFPS_P50);
  endfunction

  function automatic logic has_fn(input int i);
    return !((i == `AFPS_P05) || (i == `AFPS_P06) || (i == `AFPS_P36) ||
             (i == `AFPS_P37) || (i == `AFPS_P42));
  endfunction

  // combinational decode per pin
  generate
    for (genvar g = 0; g < NPINS; g++) begin : g_pin
      always_comb begin
        route[g] = decode(pin_mode_ctl[g],
                          {has_ext(g) & func_extension_ctl[g], has_fn(g) & func_select_ctl[g]},
                          legal_of(g)); // RULE_10 RULE_15 RULE_16 RULE_17 RULE_18 RULE_19
      end
      // registered select outputs; debug select overrides port0_bit5
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          pin_is_port[g] <= 1'b1;
          sel_a[g] <= 1'b0;
          sel_b[g] <= 1'b0;
          sel_c[g] <= 1'b0;
          sel_d[g] <= 1'b0;
        end else if (g == `AFPS_P05 && debug_mode_sel) begin
          pin_is_port[g] <= 1'b0; // RULE_05
          sel_a[g] <= 1'b0;
          sel_b[g] <= 1'b0;
          sel_c[g] <= 1'b0;
          sel_d[g] <= 1'b0;
        end else begin
          pin_is_port[g] <= (route[g] == AFPS_PORT); // RULE_01
          sel_a[g] <= (route[g] == AFPS_ALT_A);
          sel_b[g] <= (route[g] == AFPS_ALT_B);
          sel_c[g] <= (route[g] == AFPS_ALT_C);
          sel_d[g] <= (route[g] == AFPS_ALT_D);
        end
      end
    end
  endgenerate

  // debug reset input taken regardless of mode bit
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      debug_reset_sel <= 1'b0;
    end else begin
      debug_reset_sel <= debug_mode_sel; // RULE_05
    end
  end

  // status only: warns when a uart/csi use lacks its companion setting
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      uart_use_ok <= 1'b1;
    end else begin
      uart_use_ok <= !((route[`AFPS_P38] == AFPS_ALT_A && !port_output_type[`AFPS_P38]) ||
                       (route[`AFPS_P39] == AFPS_ALT_A && !port_output_type[`AFPS_P39]) ||
                       (route[`AFPS_P40] == AFPS_ALT_A && !port_output_type[`AFPS_P40]) ||
                       (route[`AFPS_P41] == AFPS_ALT_A && !port_output_type[`AFPS_P41]) ||
                       (route[`AFPS_P42] == AFPS_ALT_A && keyret_mask0)); // RULE_15 RULE_19
    end
  end

  // per pin: the mode bit decides port or alternate, except port0_bit5 under debug select; never two routes
  generate
    for (genvar h = 0; h < NPINS; h++) begin : g_chk
      a_port_clear: assert property (@(posedge clk) disable iff (rst) // RULE_01
        !pin_mode_ctl[h] && !(h == `AFPS_P05 && debug_mode_sel)
        |=> pin_is_port[h]) else $error("port mode not kept");
      a_alt_set: assert property (@(posedge clk) disable iff (rst) // RULE_01
        pin_mode_ctl[h]
        |=> !pin_is_port[h]) else $error("port kept in alternate mode");
      a_sel_onehot: assert property (@(posedge clk) disable iff (rst) // RULE_22
        $onehot0({pin_is_port[h], sel_a[h], sel_b[h], sel_c[h], sel_d[h]})) else $error("two routes on one pin");
    end
  endgenerate

  // port0_bit2 has no extension bit, so a stray one must not matter
  a_mode_clear_port: assert property (@(posedge clk) disable iff (rst) // RULE_01
    !pin_mode_ctl[`AFPS_P02]
    |=> pin_is_port[`AFPS_P02]) else $error("port mode not kept");
  a_p02_nmi_sel: assert property (@(posedge clk) disable iff (rst) // RULE_02
    pin_mode_ctl[`AFPS_P02] && !func_select_ctl[`AFPS_P02]
    |=> sel_a[`AFPS_P02]) else $error("nmi pick lost");
  a_p02_addr_sel: assert property (@(posedge clk) disable iff (rst) // RULE_02
    pin_mode_ctl[`AFPS_P02] && func_select_ctl[`AFPS_P02]
    |=> sel_b[`AFPS_P02]) else $error("address pick lost");
  a_p02_ext_ignored: assert property (@(posedge clk) disable iff (rst) // RULE_22
    pin_mode_ctl[`AFPS_P02] && !func_select_ctl[`AFPS_P02] && func_extension_ctl[`AFPS_P02]
    |=> sel_a[`AFPS_P02]) else $error("missing extension bit used");

  // port0_bit3 uses all four codes, port0_bit4 leaves code 11 reserved
  a_p03_code_00: assert property (@(posedge clk) disable iff (rst) // RULE_03
    pin_mode_ctl[`AFPS_P03] && !func_select_ctl[`AFPS_P03] && !func_extension_ctl[`AFPS_P03]
    |=> sel_a[`AFPS_P03]) else $error("irq0 not picked");
  a_p03_code_01: assert property (@(posedge clk) disable iff (rst) // RULE_03
    pin_mode_ctl[`AFPS_P03] && func_select_ctl[`AFPS_P03] && !func_extension_ctl[`AFPS_P03]
    |=> sel_b[`AFPS_P03]) else $error("trigger not picked");
  a_p03_code_10: assert property (@(posedge clk) disable iff (rst) // RULE_03
    pin_mode_ctl[`AFPS_P03] && !func_select_ctl[`AFPS_P03] && func_extension_ctl[`AFPS_P03]
    |=> sel_c[`AFPS_P03]) else $error("usb clock not picked");
  a_p03_code_11: assert property (@(posedge clk) disable iff (rst) // RULE_03
    pin_mode_ctl[`AFPS_P03] && func_select_ctl[`AFPS_P03] && func_extension_ctl[`AFPS_P03]
    |=> sel_d[`AFPS_P03]) else $error("second pulse not picked");
  a_p04_code_00: assert property (@(posedge clk) disable iff (rst) // RULE_04
    pin_mode_ctl[`AFPS_P04] && !func_select_ctl[`AFPS_P04] && !func_extension_ctl[`AFPS_P04]
    |=> sel_a[`AFPS_P04]) else $error("irq1 not picked");
  a_p04_code_01: assert property (@(posedge clk) disable iff (rst) // RULE_04
    pin_mode_ctl[`AFPS_P04] && func_select_ctl[`AFPS_P04] && !func_extension_ctl[`AFPS_P04]
    |=> sel_b[`AFPS_P04]) else $error("rtc divided not picked");
  a_p04_code_10: assert property (@(posedge clk) disable iff (rst) // RULE_04
    pin_mode_ctl[`AFPS_P04] && !func_select_ctl[`AFPS_P04] && func_extension_ctl[`AFPS_P04]
    |=> sel_c[`AFPS_P04]) else $error("rtc clock not picked");
  a_p04_reserved: assert property (@(posedge clk) disable iff (rst) // RULE_22
    pin_mode_ctl[`AFPS_P04] && func_select_ctl[`AFPS_P04] && func_extension_ctl[`AFPS_P04]
    |=> !(sel_a[`AFPS_P04] | sel_b[`AFPS_P04] | sel_c[`AFPS_P04] | sel_d[`AFPS_P04])) else $error("reserved connected");

  // debug select beats the mode bit of port0_bit5
  a_p05_debug: assert property (@(posedge clk) disable iff (rst) // RULE_05
    debug_mode_sel
    |=> debug_reset_sel && !sel_a[`AFPS_P05]) else $error("debug override missing");
  a_p05_irq2: assert property (@(posedge clk) disable iff (rst) // RULE_05
    pin_mode_ctl[`AFPS_P05] && !debug_mode_sel
    |=> sel_a[`AFPS_P05]) else $error("irq2 not picked");
  a_dbg_follow: assert property (@(posedge clk) disable iff (rst) // RULE_05
    !debug_mode_sel
    |=> !debug_reset_sel) else $error("debug reset without select");
  a_p06_irq3: assert property (@(posedge clk) disable iff (rst) // RULE_06
    pin_mode_ctl[`AFPS_P06]
    |=> sel_a[`AFPS_P06]) else $error("irq3 not picked");
  a_p06_no_fn: assert property (@(posedge clk) disable iff (rst) // RULE_06
    pin_mode_ctl[`AFPS_P06]
    |=> !(sel_b[`AFPS_P06] | sel_c[`AFPS_P06] | sel_d[`AFPS_P06])) else $error("irq3 pin left its only use");

  // port3_bit1 code 0 feeds uart receive and irq7 together
  sequence s_p31_uart_req;
    pin_mode_ctl[`AFPS_P31] && !func_select_ctl[`AFPS_P31];
  endsequence
  sequence s_p31_uart_pick;
    sel_a[`AFPS_P31] && !sel_b[`AFPS_P31];
  endsequence
  sequence s_p31_csi_req;
    pin_mode_ctl[`AFPS_P31] && func_select_ctl[`AFPS_P31];
  endsequence
  sequence s_p31_csi_pick;
    sel_b[`AFPS_P31] && !sel_a[`AFPS_P31];
  endsequence

  // port3 uart and csi4 pins
  a_p30_uart0_tx: assert property (@(posedge clk) disable iff (rst) // RULE_09
    pin_mode_ctl[`AFPS_P30] && !func_select_ctl[`AFPS_P30]
    |=> sel_a[`AFPS_P30]) else $error("uart0 tx lost");
  a_p30_csi4: assert property (@(posedge clk) disable iff (rst) // RULE_09
    pin_mode_ctl[`AFPS_P30] && func_select_ctl[`AFPS_P30]
    |=> sel_b[`AFPS_P30]) else $error("csi4 out lost");
  a_p31_rx_irq7: assert property (@(posedge clk) disable iff (rst) // RULE_10
    s_p31_uart_req
    |=> s_p31_uart_pick) else $error("uart0 rx lost");
  a_p31_csi4_in: assert property (@(posedge clk) disable iff (rst) // RULE_10
    s_p31_csi_req
    |=> s_p31_csi_pick) else $error("csi4 in lost");
  a_p32_code_00: assert property (@(posedge clk) disable iff (rst) // RULE_13
    pin_mode_ctl[`AFPS_P32] && !func_select_ctl[`AFPS_P32]
    |=> sel_a[`AFPS_P32]) else $error("baud clock lost");
  a_p32_code_01: assert property (@(posedge clk) disable iff (rst) // RULE_13
    pin_mode_ctl[`AFPS_P32] && func_select_ctl[`AFPS_P32]
    |=> sel_b[`AFPS_P32]) else $error("csi4 clock lost");
  a_p36_uart3_tx: assert property (@(posedge clk) disable iff (rst) // RULE_14
    pin_mode_ctl[`AFPS_P36]
    |=> sel_a[`AFPS_P36]) else $error("uart3 tx lost");
  a_p37_uart3_rx: assert property (@(posedge clk) disable iff (rst) // RULE_14
    pin_mode_ctl[`AFPS_P37]
    |=> sel_a[`AFPS_P37]) else $error("uart3 rx lost");

  // uart2 or csi0 on code 0, i2c on code 1
  a_p38_uart2_tx: assert property (@(posedge clk) disable iff (rst) // RULE_15
    pin_mode_ctl[`AFPS_P38] && !func_select_ctl[`AFPS_P38]
    |=> sel_a[`AFPS_P38]) else $error("uart2 tx lost");
  a_p38_i2c0_data: assert property (@(posedge clk) disable iff (rst) // RULE_15
    pin_mode_ctl[`AFPS_P38] && func_select_ctl[`AFPS_P38]
    |=> sel_b[`AFPS_P38]) else $error("i2c0 data lost");
  a_p39_uart2_rx: assert property (@(posedge clk) disable iff (rst) // RULE_16
    pin_mode_ctl[`AFPS_P39] && !func_select_ctl[`AFPS_P39]
    |=> sel_a[`AFPS_P39]) else $error("uart2 rx lost");
  a_p39_i2c0_clk: assert property (@(posedge clk) disable iff (rst) // RULE_16
    pin_mode_ctl[`AFPS_P39] && func_select_ctl[`AFPS_P39]
    |=> sel_b[`AFPS_P39]) else $error("i2c0 clock lost");
  a_p40_csi0_in: assert property (@(posedge clk) disable iff (rst) // RULE_17
    pin_mode_ctl[`AFPS_P40] && !func_select_ctl[`AFPS_P40]
    |=> sel_a[`AFPS_P40]) else $error("csi0 in lost");
  a_p40_i2c1_data: assert property (@(posedge clk) disable iff (rst) // RULE_17
    pin_mode_ctl[`AFPS_P40] && func_select_ctl[`AFPS_P40]
    |=> sel_b[`AFPS_P40]) else $error("i2c1 data lost");
  a_p41_csi0_out: assert property (@(posedge clk) disable iff (rst) // RULE_18
    pin_mode_ctl[`AFPS_P41] && !func_select_ctl[`AFPS_P41]
    |=> sel_a[`AFPS_P41]) else $error("csi0 out lost");
  a_p41_i2c1_clk: assert property (@(posedge clk) disable iff (rst) // RULE_18
    pin_mode_ctl[`AFPS_P41] && func_select_ctl[`AFPS_P41]
    |=> sel_b[`AFPS_P41]) else $error("i2c1 clock lost");
  a_p42_csi0_clk: assert property (@(posedge clk) disable iff (rst) // RULE_19
    pin_mode_ctl[`AFPS_P42]
    |=> sel_a[`AFPS_P42]) else $error("csi0 clock lost");

  // the status bit must drop when a companion setting is missing
  a_p38_type_warn: assert property (@(posedge clk) disable iff (rst) // RULE_15
    pin_mode_ctl[`AFPS_P38] && !func_select_ctl[`AFPS_P38] && !port_output_type[`AFPS_P38]
    |=> !uart_use_ok) else $error("missing output type not flagged");
  a_p42_keyret_warn: assert property (@(posedge clk) disable iff (rst) // RULE_19
    pin_mode_ctl[`AFPS_P42] && keyret_mask0
    |=> !uart_use_ok) else $error("key mask not flagged");

  // port5_bit0 leaves code 00 reserved
  a_p50_code00: assert property (@(posedge clk) disable iff (rst) // RULE_20
    pin_mode_ctl[`AFPS_P50] && !func_select_ctl[`AFPS_P50] && !func_extension_ctl[`AFPS_P50]
    |=> !sel_a[`AFPS_P50] && !pin_is_port[`AFPS_P50]) else $error("p50 code 00 connected");
  a_p50_code_01: assert property (@(posedge clk) disable iff (rst) // RULE_20
    pin_mode_ctl[`AFPS_P50] && func_select_ctl[`AFPS_P50] && !func_extension_ctl[`AFPS_P50]
    |=> sel_b[`AFPS_P50]) else $error("timer q capture lost");
  a_p50_code_10: assert property (@(posedge clk) disable iff (rst) // RULE_20
    pin_mode_ctl[`AFPS_P50] && !func_select_ctl[`AFPS_P50] && func_extension_ctl[`AFPS_P50]
    |=> sel_c[`AFPS_P50]) else $error("timer q out lost");
  a_p50_code_11: assert property (@(posedge clk) disable iff (rst) // RULE_20
    pin_mode_ctl[`AFPS_P50] && func_select_ctl[`AFPS_P50] && func_extension_ctl[`AFPS_P50]
    |=> sel_d[`AFPS_P50]) else $error("pulse out lost");
endmodule

// file: inc/afps_defs.svh
`ifndef AFPS_DEFS_SVH
`define AFPS_DEFS_SVH
// pin indices within the selection vectors
`define AFPS_P02 0
`define AFPS_P03 1
`define AFPS_P04 2
`define AFPS_P05 3
`define AFPS_P06 4
`define AFPS_P30 5
`define AFPS_P31 6
`define AFPS_P32 7
`define AFPS_P36 8
`define AFPS_P37 9
`define AFPS_P38 10
`define AFPS_P39 11
`define AFPS_P40 12
`define AFPS_P41 13
`define AFPS_P42 14
`define AFPS_P50 15
`define AFPS_NPINS 16
// {extension, function} codes
`define AFPS_SEL00 2'h0
`define AFPS_SEL01 2'h1
`define AFPS_SEL10 2'h2
`define AFPS_SEL11 2'h3
// legal {extension, function} code masks, one bit per code
`define AFPS_LEGAL_NONE 4'h0
`define AFPS_LEGAL_A 4'h1
`define AFPS_LEGAL_FN 4'h3
`define AFPS_LEGAL_P04 4'h7
`define AFPS_LEGAL_P50 4'he
`define AFPS_LEGAL_ALL 4'hf
`define AFPS_RST_SEL 16'h0000
`endif

// file: inc/afps_pkg.sv
package afps_pkg;
  // per-pin routing after decode
  typedef enum {AFPS_PORT, AFPS_ALT_A, AFPS_ALT_B, AFPS_ALT_C, AFPS_ALT_D, AFPS_NONE} afps_route_t;
endpackage

// file: tb/afps_sw_model.sv
`timescale 1ns/1ps
// software side: writes the companion bits that some alternate uses need
module afps_sw_model (
  input wire logic [15:0] mode,
  input wire logic [15:0] func,
  input wire logic [15:0] ext,
  input wire logic break_rules,
  output logic [15:0] port_output_type,
  output logic keyret_mask0,
  output logic [1:0] port_direction,
  output logic uart0_rx_enable,
  output logic irq_falling_edge_cfg,
  output logic [1:0] tmr_q_edge_cfg
);
  // both dac pins kept as outputs, so no mixed dac/io use arises
  assign port_direction = 2'h3;
  // code 0 on port3_bit1 is taken as uart receive; irq7 edges then off
  assign uart0_rx_enable = mode[6] & ~func[6];
  assign irq_falling_edge_cfg = ~uart0_rx_enable;
  // timer q capture on port5_bit0 wants its edge bits cleared
  assign tmr_q_edge_cfg = (mode[15] & func[15] & ~ext[15]) ? 2'h0 : 2'h3;
  // output type only on handed-over pins; break_rules forgets it
  assign port_output_type = break_rules ? 16'h0000 : (mode & 16'h3c00);
  // key return left unmasked unless the rules are broken on purpose
  assign keyret_mask0 = break_rules & mode[14];
endmodule

// file: tb/alt_function_pin_select_tb.sv
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin num_checks++; if ((gt) !== (ex)) begin err_count++; \
  $display("wrong value %s exp %h got %h", nm, ex, gt); end end
module alt_function_pin_select_tb;
  localparam logic [15:0] HAS_FUNC = 16'hbce7;
  localparam logic [15:0] HAS_EXT = 16'h8006;
  logic clk = 1'b0, rst = 1'b1, dbg = 1'b0, brk = 1'b0, krm, drs, uok, rxe, fec;
  logic [1:0] pdir, tqe;
  logic [15:0] mode = 16'h0000, func = 16'h0000, ext = 16'h0000, pot, ip, sa, sb, sc, sd;
  int err_count = 0, num_checks = 0;
  initial begin
    forever #5 clk = ~clk;
  end
  afps_sw_model afps_sw_model_inst (.mode(mode), .func(func), .ext(ext), .break_rules(brk),
    .port_output_type(pot), .keyret_mask0(krm), .port_direction(pdir), .uart0_rx_enable(rxe),
    .irq_falling_edge_cfg(fec), .tmr_q_edge_cfg(tqe));
  afps_pin_select afps_pin_select_inst (.clk(clk), .rst(rst), .pin_mode_ctl(mode), .func_select_ctl(func),
    .func_extension_ctl(ext), .port_output_type(pot), .debug_mode_sel(dbg), .keyret_mask0(krm),
    .pin_is_port(ip), .sel_a(sa), .sel_b(sb), .sel_c(sc), .sel_d(sd), .debug_reset_sel(drs), .uart_use_ok(uok));
  task automatic stop_test();
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // async reset must show port mode at once, no edge needed
  task automatic chk_reset();
    rst = 1'b1;
    #1;
    `CHK("reset port", 16'hffff, ip)
    `CHK("reset sel", 16'h0000, sa | sb | sc | sd)
    `CHK("reset ok", 1'b1, uok)
    `CHK("reset dbg", 1'b0, drs)
    @(negedge clk);
    rst = 1'b0;
  endtask
  // same code on every pin, so all pin decodes are judged at once
  task automatic apply(input logic [15:0] m, input logic [1:0] c, input logic d, input logic b);
    logic [15:0] ep, ea, eb, ec, ed;
    logic [1:0] k;
    logic eok;
    ep = 16'h0000; ea = 16'h0000; eb = 16'h0000; ec = 16'h0000; ed = 16'h0000;
    mode = m; func = {16{c[0]}}; ext = {16{c[1]}}; dbg = d; brk = b;
    for (int i = 0; i < 16; i++) begin
      k = {c[1] & HAS_EXT[i], c[0] & HAS_FUNC[i]};
      if (!m[i]) begin
        ep[i] = 1'b1;
      end else if (!((i == 2 && k == 2'h3) || (i == 15 && k == 2'h0))) begin
        ea[i] = (k == 2'h0); eb[i] = (k == 2'h1); ec[i] = (k == 2'h2); ed[i] = (k == 2'h3);
      end
    end
    // debug select takes port0_bit5 whatever its mode bit holds
    if (d) begin
      ep[3] = 1'b0; ea[3] = 1'b0;
    end
    eok = !(b && ((!c[0] && |m[13:10]) || m[14]));
    @(negedge clk);
    `CHK("port", ep, ip)
    `CHK("sel a", ea, sa)
    `CHK("sel b", eb, sb)
    `CHK("sel c", ec, sc)
    `CHK("sel d", ed, sd)
    `CHK("debug", d, drs)
    `CHK("uart ok", eok, uok)
    `CHK("dac dir", 2'h3, pdir)
    `CHK("irq7 edges", 1'b0, fec & sa[6])
    `CHK("rx enable", 1'b0, rxe & sb[6])
    `CHK("tq edge", 2'h0, tqe & {2{sb[15]}})
  endtask
  initial begin
    @(negedge clk);
    chk_reset();
    // every code, full and partial mode patterns, with and without companion bits
    for (int b = 0; b < 2; b++) begin
      for (int c = 0; c < 4; c++) begin
        apply(16'hffff, c[1:0], 1'b0, b[0]);
        apply(16'ha5a5, c[1:0], 1'b0, b[0]);
      end
    end
    apply(16'hffff, 2'h0, 1'b1, 1'b0);
    apply(16'h0000, 2'h1, 1'b1, 1'b0);
    apply(16'h5a5a, 2'h3, 1'b0, 1'b0);
    chk_reset();
    apply(16'hffff, 2'h2, 1'b0, 1'b1);
    stop_test();
  end
  // whole run is a few hundred ns; far beyond that means a hang
  initial begin
    #100000;
    err_count++;
    stop_test();
  end
endmodule
